/* verilog/tied_top.sv */
// Timer with filtered input edge detection, capture and Wishbone registers
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "tied_params.svh"
// Functional notes
// - A high input after reset gives a rising edge as soon as counting starts.
// - A fall during a stop from high gives a falling edge on re-enable.
// - A rise during a stop from low gives a rising edge on re-enable.
// - As count clock the input is sampled on every peripheral clock.
// - As capture trigger the input is sampled at the prescaled count clock.
// - An edge counts only after the new level is seen on two samples.
// - The event count sits in the 16-bit counter and is read from there.
module tied_top (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer pins
  input wire logic first_capture_input,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe
);
  // Register map, byte offsets on the bus:
  //   CTRL 0x00, PRESC 0x04, COMPARE 0x08, COUNT 0x0c (read only),
  //   CAPT0 0x10 and CAPT1 0x14 (read only), STATUS 0x18 (write 1 clears).
  // CTRL bits: 0 run, 1 event mode, 2 capture enable, 4:3 first edge,
  //   6:5 second edge, 7 shared pin as timer output.
  // PRESC picks the count clock as clock/4, /16, /64 or /256.

  // Bus side
  tied_pkg::tied_wb_req_t req;
  logic next_ack;
  logic [31:0] next_rdata;
  logic [31:0] wr_word;
  logic wr_stb;

  // Software-visible registers
  tied_pkg::tied_ctrl_t ctrl;
  tied_pkg::tied_ctrl_t next_ctrl;
  logic [1:0] prescaler_mode_setting;
  logic [1:0] next_presc;
  logic [15:0] first_compare_register;
  logic [15:0] next_compare;
  logic [`TIED_ST_W-1:0] status;
  logic [`TIED_ST_W-1:0] next_status;
  logic [`TIED_ST_W-1:0] st_set;
  logic [`TIED_ST_W-1:0] st_clr;

  // Counting, capture and timer output
  logic [15:0] timer_counter_16b;
  logic [15:0] next_count;
  logic [15:0] capt0;
  logic [15:0] next_capt0;
  logic [15:0] capt1;
  logic [15:0] next_capt1;
  logic timer_output_pin;
  logic next_out;
  logic next_pin_o;
  logic presc_tick;
  logic count_tick;
  logic match;
  logic wrap;

  // Per-input filter wiring
  logic [`TIED_NUM_IN-1:0] pins;
  logic [`TIED_NUM_IN-1:0] samp_en;
  logic [`TIED_NUM_IN-1:0] in_en;
  logic [`TIED_NUM_IN-1:0] edges;
  tied_pkg::tied_edge_t sels [`TIED_NUM_IN];

  // Merge a write into a word under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Gather the bus request into one carrier
  always_comb begin
    req.cyc = wb_cyc_i;
    req.stb = wb_stb_i;
    req.we = wb_we_i;
    req.adr = wb_adr_i;
    req.sel = wb_sel_i;
    req.dat = wb_dat_i;
  end

  // Count clock divider
  tied_prescaler u_presc (
    .clock(clock),
    .resetn(resetn),
    .prescaler_mode_setting(prescaler_mode_setting),
    .tick(presc_tick)
  );

  // Per-input selection of pin, sampling rate, enable and edge
  always_comb begin
    // Second input shares its pin with the timer output
    pins[0] = first_capture_input;
    pins[1] = shared_port_pin_i;
    sels[0] = ctrl.sel_first;
    sels[1] = ctrl.sel_second;
    // Count clock input is sampled at the undivided clock
    samp_en[0] = ctrl.event_mode ? 1'b1 : presc_tick;
    samp_en[1] = presc_tick;
    in_en[0] = ctrl.run;
    // Shared pin as output gives no second edge at all
    in_en[1] = ctrl.run & ~ctrl.pin_is_output;
  end

  // One filter and edge detector per input
  generate
    for (genvar i = 0; i < `TIED_NUM_IN; i++) begin : g_in
      tied_filter u_filt (
        .clock(clock),
        .resetn(resetn),
        .sample_en(samp_en[i]),
        .enable(in_en[i]),
        .edge_sel(sels[i]),
        .pin(pins[i]),
        .level(),
        .edge_pulse(edges[i])
      );
    end
  endgenerate

  // Counter ticks on first input edges in event mode, else prescaler
  always_comb begin
    count_tick = ctrl.run & (ctrl.event_mode ? edges[0] : presc_tick);
    match = count_tick & (timer_counter_16b == first_compare_register);
    // Overflow only on a real wrap, never on a compare clear
    wrap = count_tick & ~match & (timer_counter_16b == `TIED_COUNT_MAX);
    next_count = timer_counter_16b;
    next_out = timer_output_pin;
    // A stopped counter sits at zero, so a restart counts from the start
    if (!ctrl.run) begin
      next_count = `TIED_COUNT_RESET;
    end else if (match) begin
      // Interval mode clears on compare match and toggles the output
      next_count = `TIED_COUNT_RESET;
      next_out = ~timer_output_pin;
    end else if (count_tick) begin
      next_count = timer_counter_16b + `TIED_COUNT_ONE;
    end
  end

  // Capture on filtered edges; first input only when not the count clock
  always_comb begin
    next_capt0 = capt0;
    next_capt1 = capt1;
    st_set = '0;
    if (ctrl.capture_en && !ctrl.event_mode && edges[0]) begin
      next_capt0 = timer_counter_16b;
      st_set[`TIED_ST_CAPT0] = 1'b1;
    end
    if (ctrl.capture_en && edges[1]) begin
      next_capt1 = timer_counter_16b;
      st_set[`TIED_ST_CAPT1] = 1'b1;
    end
    st_set[`TIED_ST_MATCH] = match;
    st_set[`TIED_ST_OVF] = wrap;
  end

  // Shared pin drives the timer output only when configured so; the level
  // is built from next values so that it turns off with the enable
  always_comb begin
    shared_port_pin_oe = ctrl.pin_is_output;
    next_pin_o = next_out & next_ctrl.pin_is_output;
  end

  // Bus slave: one wait cycle, ack drops the cycle after it was given
  always_comb begin
    next_ack = req.cyc & req.stb & ~wb_ack_o;
    wr_stb = next_ack & req.we;
  end

  // Register writes; compare may be written while running at user risk
  always_comb begin
    next_ctrl = ctrl;
    next_presc = prescaler_mode_setting;
    next_compare = first_compare_register;
    st_clr = '0;
    wr_word = '0;
    if (wr_stb) begin
      case (req.adr)
        // Only the low byte holds control bits; upper lanes are dropped
        `TIED_ADR_CTRL: begin
          wr_word = merge({24'h000000, ctrl}, req.dat, req.sel);
          next_ctrl = tied_pkg::tied_ctrl_t'(wr_word[7:0]);
        end
        // Divider select lives in the lowest lane only
        `TIED_ADR_PRESC: begin
          if (req.sel[0]) begin
            next_presc = req.dat[1:0];
          end
        end
        // Lanes merged under the byte enables; the upper half is ignored
        `TIED_ADR_COMPARE: begin
          wr_word = merge({16'h0000, first_compare_register},
                          req.dat, req.sel);
          next_compare = wr_word[15:0];
        end
        // Write one to clear; count and capture offsets are read only
        `TIED_ADR_STATUS: begin
          if (req.sel[0]) begin
            st_clr = req.dat[`TIED_ST_W-1:0];
          end
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    // A flag set in the cycle of its clear stays set
    next_status = (status & ~st_clr) | st_set;
  end

  // Read mux; unmapped offsets read zero and are still acknowledged
  always_comb begin
    next_rdata = wb_dat_o;
    if (next_ack) begin
      case (req.adr)
        `TIED_ADR_CTRL: next_rdata = {24'h000000, ctrl};
        `TIED_ADR_PRESC: next_rdata = {30'h00000000,
                                       prescaler_mode_setting};
        `TIED_ADR_COMPARE: next_rdata = {16'h0000,
                                         first_compare_register};
        `TIED_ADR_COUNT: next_rdata = {16'h0000,
                                       timer_counter_16b};
        `TIED_ADR_CAPT0: next_rdata = {16'h0000, capt0};
        `TIED_ADR_CAPT1: next_rdata = {16'h0000, capt1};
        `TIED_ADR_STATUS: next_rdata = {28'h0000000, status};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Bus response state; read data holds between acknowledges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // Configuration and status state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= tied_pkg::tied_ctrl_t'(`TIED_CTRL_RESET);
      prescaler_mode_setting <= `TIED_PRESC_RESET;
      first_compare_register <= `TIED_COMPARE_RESET;
      status <= '0;
    end else begin
      ctrl <= next_ctrl;
      prescaler_mode_setting <= next_presc;
      first_compare_register <= next_compare;
      status <= next_status;
    end
  end

  // Counting state and the registered timer output level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_counter_16b <= `TIED_COUNT_RESET;
      timer_output_pin <= 1'b0;
      shared_port_pin_o <= 1'b0;
    end else begin
      timer_counter_16b <= next_count;
      timer_output_pin <= next_out;
      shared_port_pin_o <= next_pin_o;
    end
  end

  // Capture state; a capture register holds until the next capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      capt0 <= `TIED_COUNT_RESET;
      capt1 <= `TIED_COUNT_RESET;
    end else begin
      capt0 <= next_capt0;
      capt1 <= next_capt1;
    end
  end
endmodule

/* verilog/tied_params.svh */
// Offsets, field positions, reset values and divider masks of the block
`ifndef TIED_PARAMS_SVH
`define TIED_PARAMS_SVH
`define TIED_ADR_W 8
`define TIED_ADR_CTRL 8'h00
`define TIED_ADR_PRESC 8'h04
`define TIED_ADR_COMPARE 8'h08
`define TIED_ADR_COUNT 8'h0c
`define TIED_ADR_CAPT0 8'h10
`define TIED_ADR_CAPT1 8'h14
`define TIED_ADR_STATUS 8'h18
`define TIED_CTRL_RESET 8'h00
`define TIED_PRESC_RESET 2'h0
`define TIED_COMPARE_RESET 16'hffff
`define TIED_COUNT_RESET 16'h0000
`define TIED_COUNT_ONE 16'h0001
`define TIED_COUNT_MAX 16'hffff
`define TIED_ST_CAPT0 0
`define TIED_ST_CAPT1 1
`define TIED_ST_MATCH 2
`define TIED_ST_OVF 3
`define TIED_ST_W 4
`define TIED_DIV_MASK0 8'h03
`define TIED_DIV_MASK1 8'h0f
`define TIED_DIV_MASK2 8'h3f
`define TIED_DIV_MASK3 8'hff
`define TIED_NUM_IN 2
`endif

/* verilog/tied_pkg.sv */
// Types shared by the timer input edge detection block
package tied_pkg;
  // Valid edge selection of one capture input
  typedef enum logic [1:0] {
    TIED_EDGE_NONE = 2'h0,
    TIED_EDGE_RISE = 2'h1,
    TIED_EDGE_FALL = 2'h2,
    TIED_EDGE_BOTH = 2'h3
  } tied_edge_t;
  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic pin_is_output;
    tied_edge_t sel_second;
    tied_edge_t sel_first;
    logic capture_en;
    logic event_mode;
    logic run;
  } tied_ctrl_t;
  // Wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tied_wb_req_t;
endpackage

/* verilog/tied_prescaler.sv */
// Count clock divider giving a one-cycle tick at the selected rate
`timescale 1ns/1ps
`include "tied_params.svh"
module tied_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Rate select and tick
  input wire logic [1:0] prescaler_mode_setting,
  output logic tick
);
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic [7:0] mask;
  logic next_tick;

  // Free-running divider; tick when the masked low bits wrap to zero
  always_comb begin
    next_div_cnt = div_cnt + 8'h01;
    case (prescaler_mode_setting)
      2'h0: mask = `TIED_DIV_MASK0;
      2'h1: mask = `TIED_DIV_MASK1;
      2'h2: mask = `TIED_DIV_MASK2;
      default: mask = `TIED_DIV_MASK3;
    endcase
    next_tick = ((next_div_cnt & mask) == 8'h00);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end
endmodule

/* verilog/tied_filter.sv */
// Two-sample noise filter and valid edge detector for one input
`timescale 1ns/1ps
module tied_filter (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Sampling and control
  input wire logic sample_en,
  input wire logic enable,
  input wire tied_pkg::tied_edge_t edge_sel,
  // Pin and results
  input wire logic pin,
  output logic level,
  output logic edge_pulse
);
  logic samp_a;
  logic prev;
  logic next_samp_a;
  logic next_level;
  logic next_prev;
  logic next_pulse;
  logic rise;
  logic fall;

  // Sampler runs even while stopped, so a level change made during the
  // stop is already filtered when the counter is enabled again
  always_comb begin
    next_samp_a = samp_a;
    next_level = level;
    if (sample_en) begin
      next_samp_a = pin;
      if (pin == samp_a) begin
        next_level = pin;
      end
    end
  end

  // Stored level is frozen while disabled and starts low after reset
  always_comb begin
    rise = level & ~prev;
    fall = ~level & prev;
    next_prev = enable ? level : prev;
    next_pulse = 1'b0;
    if (enable) begin
      case (edge_sel)
        tied_pkg::TIED_EDGE_RISE: next_pulse = rise;
        tied_pkg::TIED_EDGE_FALL: next_pulse = fall;
        tied_pkg::TIED_EDGE_BOTH: next_pulse = rise | fall;
        default: next_pulse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      samp_a <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      samp_a <= next_samp_a;
      level <= next_level;
      prev <= next_prev;
      edge_pulse <= next_pulse;
    end
  end
endmodule

/* verif/tied_monitor.sv */
// Bus and shared pin checker for the timer input block
`timescale 1ns/1ps
`include "tied_params.svh"
module tied_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Shared pin
  input wire logic shared_port_pin_o,
  input wire logic shared_port_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // A read being taken at this edge
  logic rd;
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held longer than one cycle");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing one cycle after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hold;
    !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved outside ack");
  property p_unmapped;
    rd && wb_adr_i > `TIED_ADR_STATUS |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_count_w;
    rd && wb_adr_i == `TIED_ADR_COUNT |=> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_count_w: assert property (p_count_w)
    else $error("count wider than 16 bits");
  property p_status_w;
    rd && wb_adr_i == `TIED_ADR_STATUS |=> wb_dat_o[31:4] == 28'h0;
  endproperty
  a_status_w: assert property (p_status_w)
    else $error("status upper bits set");
  property p_out_gate;
    !shared_port_pin_oe |-> !shared_port_pin_o;
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("timer output active while pin is input");
  // Pin role moves only by a control write
  property p_oe_write;
    $changed(shared_port_pin_oe) |-> $past(wb_cyc_i && wb_stb_i
      && wb_we_i && wb_adr_i == `TIED_ADR_CTRL);
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("pin role changed without control write");
  c_write: cover property (wb_ack_o && $past(wb_we_i));
  c_read: cover property (wb_ack_o && $past(!wb_we_i));
  c_oe: cover property (shared_port_pin_oe);
endmodule
bind tied_top tied_monitor i_mon (
  .clock(clock),
  .resetn(resetn),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .shared_port_pin_o(shared_port_pin_o),
  .shared_port_pin_oe(shared_port_pin_oe)
);

/* verif/tied_src.sv */
// Behavioural signal source driving the two timer input pins
`timescale 1ns/1ps
module tied_src (
  // Clock
  input wire logic clock,
  // Driven pins
  output logic pin_a,
  output logic pin_b
);
  // First pin high at power-up, so the first enable meets a high level
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b0;
  end
  // Change one pin just after an edge, then hold it
  task automatic drive(input logic b, input logic v, input int hold);
    if (b)
      pin_b <= v;
    else
      pin_a <= v;
    repeat (hold) @(posedge clock);
  endtask
  // High for width cycles, then low for gap cycles
  task automatic pulse(input logic b, input int width, input int gap);
    drive(b, 1'b1, width);
    drive(b, 1'b0, gap);
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the timer input edge detection block
`timescale 1ns/1ps
`include "tied_params.svh"
module tb_top;
  // Bus drive, pins and counters
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, dat_o;
  logic [31:0] rnd = 32'h848fbadc;
  logic ack, po, poe, pa, pb, shared;
  int mismatches = 0, comparisons = 0, n;
  // Shared pin level from whichever side drives it
  assign shared = poe ? po : pb;
  always #2 clock = ~clock;
  tied_src i_src (.clock(clock), .pin_a(pa), .pin_b(pb));
  tied_top i_dut (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .first_capture_input(pa), .shared_port_pin_i(shared),
    .shared_port_pin_o(po), .shared_port_pin_oe(poe));
  // Pseudo-random step with a fixed seed, so runs repeat
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Events for k pulses; both edges count twice
  function automatic logic [31:0] exp_cnt(input int k, input logic both);
    return both ? 32'(2 * k) : 32'(k);
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clock);
    // Only the watchdog ends a wait that never sees ack
    while (ack !== 1'b1) begin
      @(posedge clock);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_chk(`TIED_ADR_CTRL, 32'h0);
    rd_chk(`TIED_ADR_PRESC, 32'h0);
    rd_chk(`TIED_ADR_COMPARE, 32'hffff);
    rd_chk(`TIED_ADR_COUNT, 32'h0);
    rd_chk(`TIED_ADR_STATUS, 32'h0);
    rd_chk(8'h1c, 32'h0);
    // Pin high since reset: the first enable counts at once
    xfer(1'b1, `TIED_ADR_CTRL, 32'h0b);
    repeat (10) @(posedge clock);
    rd_chk(`TIED_ADR_COUNT, 32'h1);
    i_src.drive(1'b0, 1'b0, 8);
    // Random pulse trains, shortest legal widths included, then a glitch
    for (int b = 0; b < 2; b++) begin
      xfer(1'b1, `TIED_ADR_CTRL, 32'h0a);
      xfer(1'b1, `TIED_ADR_CTRL, b == 1 ? 32'h1b : 32'h0b);
      rnd = lfsr(rnd);
      n = 1 + rnd[1:0];
      for (int k = 0; k < n; k++) begin
        rnd = lfsr(rnd);
        i_src.pulse(1'b0, 2 + rnd[2:0], 2 + rnd[5:3]);
      end
      i_src.pulse(1'b0, 1, 8);
      rd_chk(`TIED_ADR_COUNT, exp_cnt(n, b == 1));
    end
    // Stop high, fall while stopped, re-enable on falling edges
    i_src.drive(1'b0, 1'b1, 8);
    xfer(1'b1, `TIED_ADR_CTRL, 32'h12);
    i_src.drive(1'b0, 1'b0, 8);
    xfer(1'b1, `TIED_ADR_CTRL, 32'h13);
    repeat (8) @(posedge clock);
    rd_chk(`TIED_ADR_COUNT, 32'h1);
    // Stop low, rise while stopped, re-enable on rising edges
    xfer(1'b1, `TIED_ADR_CTRL, 32'h0a);
    i_src.drive(1'b0, 1'b1, 8);
    xfer(1'b1, `TIED_ADR_CTRL, 32'h0b);
    repeat (8) @(posedge clock);
    rd_chk(`TIED_ADR_COUNT, 32'h1);
    // Capture on second input, sampled at clock/4
    xfer(1'b1, `TIED_ADR_CTRL, 32'h25);
    i_src.pulse(1'b1, 3, 20);
    rd_chk(`TIED_ADR_STATUS, 32'h0);
    i_src.pulse(1'b1, 24, 20);
    rd_chk(`TIED_ADR_STATUS, 32'h2);
    xfer(1'b1, `TIED_ADR_STATUS, 32'h2);
    rd_chk(`TIED_ADR_STATUS, 32'h0);
    // Divider at clock/16: a 12-cycle pulse meets one sample only
    xfer(1'b1, `TIED_ADR_CTRL, 32'h24);
    xfer(1'b1, `TIED_ADR_PRESC, 32'h1);
    rd_chk(`TIED_ADR_PRESC, 32'h1);
    xfer(1'b1, `TIED_ADR_CTRL, 32'h25);
    i_src.pulse(1'b1, 12, 40);
    rd_chk(`TIED_ADR_STATUS, 32'h0);
    i_src.pulse(1'b1, 40, 40);
    rd_chk(`TIED_ADR_STATUS, 32'h2);
    xfer(1'b1, `TIED_ADR_STATUS, 32'h2);
    // Retune divider and compare only while stopped
    xfer(1'b1, `TIED_ADR_CTRL, 32'h0);
    xfer(1'b1, `TIED_ADR_PRESC, 32'h0);
    xfer(1'b1, `TIED_ADR_COMPARE, 32'h3);
    rd_chk(`TIED_ADR_COMPARE, 32'h3);
    // Shared pin as output loops the toggling timer output back in,
    // yet the second input must stay deaf; only the match flag rises
    xfer(1'b1, `TIED_ADR_CTRL, 32'ha5);
    rd_chk(`TIED_ADR_CTRL, 32'ha5);
    check({31'h0, poe}, 32'h1);
    n = 0;
    repeat (48) begin
      @(posedge clock);
      n += po;
    end
    check({31'h0, n != 0}, 32'h1);
    i_src.pulse(1'b1, 24, 20);
    rd_chk(`TIED_ADR_STATUS, 32'h4);
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
endmodule
